// *** ocram_pkg.sv ***
// constants and carrier types of the on-chip ram controller
// How it works
// - main ram answers the 512 KB window 0000_0000 to 0007_ffff.
// - every main ram read or write finishes in one cycle.
// - a control bit enables or disables the whole main ram.
// - main and expansion ram words carry parity; a single flipped bit is seen.
// - each memory error whose mask bit is set raises nmi or irq, picked by a control bit.
// - expansion ram answers the 512 KB window 0080_0000 to 0087_ffff.
// - a separate control bit enables or disables expansion ram.
// - expansion ram takes one cycle, or two with wait select set.
// - ecc ram answers the 32 KB window 00ff_8000 to 00ff_ffff.
// - ecc ram enable is a separate bit from the ecc function enable.
// - wait select 0: ecc ram takes two cycles, three on an error.
// - wait select 1: three off, three read, four write, five on error.
// - with ecc on, one bad bit is corrected and two are detected.
// - each of the three rams has its own module stop bit.
// - contents are not kept across deep standby; software treats them lost.
package ocram_pkg;

   // ---------------------------------------------------------------
   // address map of the memory port
   // ---------------------------------------------------------------
   localparam logic [31:0] MAIN_BASE = 32'h0000_0000;
   localparam logic [31:0] MAIN_LAST = 32'h0007_ffff;
   localparam logic [31:0] EXP_BASE  = 32'h0080_0000;
   localparam logic [31:0] EXP_LAST  = 32'h0087_ffff;
   localparam logic [31:0] ECC_BASE  = 32'h00ff_8000;
   localparam logic [31:0] ECC_LAST  = 32'h00ff_ffff;
   // storage really built per region; higher word indexes alias onto it
   localparam int          IDX_W     = 8;
   localparam int          MEM_WORDS = 256;
   localparam int          PAR_W     = 33;
   localparam int          ECC_W     = 39;

   // ---------------------------------------------------------------
   // register map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL     = 8'h00;
   localparam logic [7:0]  REG_STATUS   = 8'h04;
   localparam logic [7:0]  REG_MASK     = 8'h08;
   localparam logic [7:0]  REG_ERR_ADDR = 8'h0c;
   localparam logic [7:0]  REG_INJECT   = 8'h10;
   localparam int          CTL_MAIN_EN  = 0;
   localparam int          CTL_EXP_EN   = 1;
   localparam int          CTL_ECC_EN   = 2;
   localparam int          CTL_ECC_FN   = 3;
   localparam int          CTL_WAIT     = 4;
   localparam int          CTL_NMI      = 5;
   localparam int          CTL_STOP_MN  = 8;
   localparam int          CTL_STOP_EX  = 9;
   localparam int          CTL_STOP_EC  = 10;
   localparam logic [31:0] CTRL_RST     = 32'h0000_000f;
   localparam int          ST_W         = 5;
   localparam int          EV_MAIN_PAR  = 0;
   localparam int          EV_EXP_PAR   = 1;
   localparam int          EV_ECC_FIX   = 2;
   localparam int          EV_ECC_DBL   = 3;
   localparam int          EV_LOST      = 4;

   // ---------------------------------------------------------------
   // access lengths in cycles
   // ---------------------------------------------------------------
   localparam logic [2:0]  LAT_ONE      = 3'h1;
   localparam logic [2:0]  LAT_EXP_W1   = 3'h2;
   localparam logic [2:0]  LAT_ECC_W0   = 3'h2;
   localparam logic [2:0]  LAT_ECC_W0E  = 3'h3;
   localparam logic [2:0]  LAT_ECC_W1   = 3'h3;
   localparam logic [2:0]  LAT_ECC_W1WR = 3'h4;
   localparam logic [2:0]  LAT_ECC_W1E  = 3'h5;

   typedef enum logic [1:0] {RG_NONE = 2'h0, RG_MAIN = 2'h1, RG_EXP = 2'h2,
                             RG_ECC = 2'h3} region_t;
   typedef enum logic {ST_IDLE = 1'b0, ST_WAIT = 1'b1} state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic        ready;
      logic        done;
      logic        err;
      logic        merr;
      logic        fixed;
      logic [31:0] rdata;
   } mem_rsp_t;

   typedef struct packed {
      logic [31:0] data;
      logic        single;
      logic        dbl;
   } ecc_res_t;

endpackage

// *** onchip_ram_parity_ecc_ctrl.sv ***
// on-chip ram controller: three regions, parity and ecc, ahb-lite control
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module onchip_ram_parity_ecc_ctrl
   import ocram_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire mem_req_t    mem_req,
   output mem_rsp_t         mem_rsp,
   input  wire logic        deep_standby,
   output logic             irq,
   output logic             nmi
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic region_t region_of(input logic [31:0] a);
      if (a >= MAIN_BASE && a <= MAIN_LAST) return RG_MAIN;
      if (a >= EXP_BASE && a <= EXP_LAST)   return RG_EXP;
      if (a >= ECC_BASE && a <= ECC_LAST)   return RG_ECC;
      return RG_NONE;
   endfunction

   // data bit i owns the i-th non power of two code from 3 upward
   function automatic logic [6:0] ecc_check(input logic [31:0] d);
      logic [5:0] c;
      logic [5:0] code;
      c    = 6'h00;
      code = 6'h03;
      for (int i = 0; i < 32; i++) begin
         if ((code & (code - 6'h01)) == 6'h00) code = code + 6'h01;
         if (d[i]) c = c ^ code;
         code = code + 6'h01;
      end
      return {^{d, c}, c};
   endfunction

   function automatic ecc_res_t ecc_fix(input logic [ECC_W-1:0] w);
      ecc_res_t   r;
      logic [6:0] chk;
      logic [5:0] syn;
      logic [5:0] code;
      logic       odd;
      chk      = ecc_check(w[31:0]);
      syn      = chk[5:0] ^ w[37:32];
      odd      = ^w;
      r.data   = w[31:0];
      r.single = odd;
      r.dbl    = !odd && (syn != 6'h00);
      code     = 6'h03;
      for (int i = 0; i < 32; i++) begin
         if ((code & (code - 6'h01)) == 6'h00) code = code + 6'h01;
         if (odd && syn == code) r.data[i] = !w[i];
         code = code + 6'h01;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   state_t            state_ff;
   logic [2:0]        wait_ff;
   mem_rsp_t          rsp_ff;
   logic [31:0]       ctrl_ff;
   logic [ST_W-1:0]   status_ff;
   logic [ST_W-1:0]   mask_ff;
   logic [31:0]       err_addr_ff;
   logic [31:0]       inject_ff;
   logic              standby_ff;
   logic              ap_valid_ff;
   logic              ap_write_ff;
   logic [7:0]        ap_addr_ff;
   logic [31:0]       hrdata_ff;
   logic              hreadyout_ff;
   logic              hresp_ff;
   logic              irq_ff;
   logic              nmi_ff;
   logic [ECC_W-1:0]  ecc_mem [MEM_WORDS];
   logic [PAR_W-1:0]  par_rd [2];

   region_t           rg;
   logic [IDX_W-1:0]  idx;
   logic              take;
   logic              fault;
   logic              acc_wr;
   logic              ecc_on;
   logic              par_bad;
   logic [PAR_W-1:0]  par_word;
   ecc_res_t          ecc_rd;
   logic              ecc_err;
   logic [2:0]        lat;
   logic [31:0]       store_data;
   logic [ST_W-1:0]   ev;
   logic              reg_wr;
   logic [31:0]       nxt_ctrl;
   logic [ST_W-1:0]   nxt_status;
   logic [ST_W-1:0]   nxt_mask;
   logic [31:0]       rd_val;

   // ---------------------------------------------------------------
   // access decode
   // ---------------------------------------------------------------
   always_comb begin
      rg         = region_of(mem_req.addr);
      idx        = mem_req.addr[IDX_W+1:2];
      take       = mem_req.valid && (state_ff == ST_IDLE);
      ecc_on     = ctrl_ff[CTL_ECC_FN];
      unique case (rg)
         RG_MAIN: fault = !ctrl_ff[CTL_MAIN_EN] || ctrl_ff[CTL_STOP_MN];
         RG_EXP:  fault = !ctrl_ff[CTL_EXP_EN] || ctrl_ff[CTL_STOP_EX];
         RG_ECC:  fault = !ctrl_ff[CTL_ECC_EN] || ctrl_ff[CTL_STOP_EC];
         RG_NONE: fault = 1'b1;
      endcase
      // nothing is promised to survive deep standby, so it is simply refused
      fault      = fault || deep_standby;
      acc_wr     = take && !fault && mem_req.write;
      par_word   = par_rd[rg == RG_EXP];
      par_bad    = ^par_word;
      ecc_rd     = ecc_fix(ecc_mem[idx]);
      // full-word writes never read old data, so they cannot see an error
      ecc_err    = ecc_on && !mem_req.write && (ecc_rd.single || ecc_rd.dbl);
      store_data = mem_req.wdata ^ inject_ff;
      lat        = LAT_ONE;
      if (!fault && rg == RG_EXP && ctrl_ff[CTL_WAIT]) lat = LAT_EXP_W1;
      if (!fault && rg == RG_ECC) begin
         if (!ctrl_ff[CTL_WAIT]) lat = ecc_err ? LAT_ECC_W0E : LAT_ECC_W0;
         else if (!ecc_on) lat = LAT_ECC_W1;
         else if (ecc_err) lat = LAT_ECC_W1E;
         else lat = mem_req.write ? LAT_ECC_W1WR : LAT_ECC_W1;
      end
      ev              = '0;
      ev[EV_MAIN_PAR] = take && !fault && !mem_req.write && rg == RG_MAIN && par_bad;
      ev[EV_EXP_PAR]  = take && !fault && !mem_req.write && rg == RG_EXP && par_bad;
      ev[EV_ECC_FIX]  = take && !fault && rg == RG_ECC && ecc_err && ecc_rd.single;
      ev[EV_ECC_DBL]  = take && !fault && rg == RG_ECC && ecc_err && ecc_rd.dbl;
      ev[EV_LOST]     = deep_standby && !standby_ff;
   end

   // ---------------------------------------------------------------
   // storage, no reset: contents are undefined until written
   // ---------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_par
      logic [PAR_W-1:0] mem [MEM_WORDS];
      always_ff @(posedge clk) begin
         if (acc_wr && rg == ((g == 0) ? RG_MAIN : RG_EXP)) begin
            mem[idx] <= {^mem_req.wdata, store_data};
         end
      end
      assign par_rd[g] = mem[idx];
   end

   always_ff @(posedge clk) begin
      if (acc_wr && rg == RG_ECC) begin
         ecc_mem[idx] <= {ecc_check(mem_req.wdata), store_data};
      end
   end

   // ---------------------------------------------------------------
   // access sequencing and answer
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff     <= ST_IDLE;
         wait_ff      <= 3'h0;
         rsp_ff       <= '0;
         rsp_ff.ready <= 1'b1;
      end else begin
         rsp_ff.done <= 1'b0;
         if (take) begin
            rsp_ff.err   <= fault;
            rsp_ff.merr  <= !fault && !mem_req.write &&
                            ((rg != RG_ECC && par_bad) || (rg == RG_ECC && ecc_on && ecc_rd.dbl));
            rsp_ff.fixed <= !fault && rg == RG_ECC && ecc_err && ecc_rd.single;
            if (fault || mem_req.write) rsp_ff.rdata <= 32'h0000_0000;
            else if (rg == RG_ECC) rsp_ff.rdata <= ecc_on ? ecc_rd.data : ecc_mem[idx][31:0];
            else rsp_ff.rdata <= par_word[31:0];
            if (lat == LAT_ONE) begin
               rsp_ff.done <= 1'b1;
            end else begin
               state_ff     <= ST_WAIT;
               wait_ff      <= lat - 3'h2;
               rsp_ff.ready <= 1'b0;
            end
         end else if (state_ff == ST_WAIT) begin
            if (wait_ff == 3'h0) begin
               state_ff     <= ST_IDLE;
               rsp_ff.done  <= 1'b1;
               rsp_ff.ready <= 1'b1;
            end else begin
               wait_ff <= wait_ff - 3'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // register next values
   // ---------------------------------------------------------------
   always_comb begin
      reg_wr     = ap_valid_ff && ap_write_ff;
      nxt_ctrl   = ctrl_ff;
      nxt_mask   = mask_ff;
      nxt_status = status_ff;
      if (reg_wr && ap_addr_ff == REG_CTRL) nxt_ctrl = hwdata & 32'h0000_073f;
      if (reg_wr && ap_addr_ff == REG_MASK) nxt_mask = hwdata[ST_W-1:0];
      if (reg_wr && ap_addr_ff == REG_STATUS) nxt_status = status_ff & ~hwdata[ST_W-1:0];
      nxt_status = nxt_status | ev;                            // an event beats its clear
      unique case (haddr[7:0])
         REG_CTRL:     rd_val = ctrl_ff;
         REG_STATUS:   rd_val = {{(32 - ST_W){1'b0}}, status_ff};
         REG_MASK:     rd_val = {{(32 - ST_W){1'b0}}, mask_ff};
         REG_ERR_ADDR: rd_val = err_addr_ff;
         REG_INJECT:   rd_val = inject_ff;
         default:      rd_val = 32'h0000_0000;
      endcase
   end

   // ---------------------------------------------------------------
   // ahb-lite slave, zero wait
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ap_valid_ff  <= 1'b0;
         ap_write_ff  <= 1'b0;
         ap_addr_ff   <= 8'h00;
         hrdata_ff    <= 32'h0000_0000;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end else if (hready) begin
         ap_valid_ff <= hsel && htrans[1];
         ap_write_ff <= hwrite;
         ap_addr_ff  <= haddr[7:0];
         hrdata_ff   <= (hsel && htrans[1] && !hwrite) ? rd_val : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // control, status and interrupt lines
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff     <= CTRL_RST;
         mask_ff     <= '0;
         status_ff   <= '0;
         err_addr_ff <= 32'h0000_0000;
         standby_ff  <= 1'b0;
         irq_ff      <= 1'b0;
         nmi_ff      <= 1'b0;
      end else begin
         ctrl_ff    <= nxt_ctrl;
         mask_ff    <= nxt_mask;
         status_ff  <= nxt_status;
         standby_ff <= deep_standby;
         if (|ev[EV_ECC_DBL:EV_MAIN_PAR]) err_addr_ff <= mem_req.addr;
         irq_ff     <= |(nxt_status & nxt_mask) && !nxt_ctrl[CTL_NMI];
         nmi_ff     <= |(nxt_status & nxt_mask) && nxt_ctrl[CTL_NMI];
      end
   end

   // one-shot flip mask for testing the checkers; software write wins
   always_ff @(posedge clk) begin
      if (rst) begin
         inject_ff <= 32'h0000_0000;
      end else if (reg_wr && ap_addr_ff == REG_INJECT) begin
         inject_ff <= hwdata;
      end else if (acc_wr) begin
         inject_ff <= 32'h0000_0000;
      end
   end

   assign mem_rsp   = rsp_ff;
   assign hrdata    = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp     = hresp_ff;
   assign irq       = irq_ff;
   assign nmi       = nmi_ff;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_main_one;
      @(posedge clk) disable iff (rst)
      (take && !fault && rg == RG_MAIN) |=> mem_rsp.done && mem_rsp.ready;
   endproperty
   a_main_one: assert property (p_main_one) else $error("main access not one cycle");

   property p_outside;
      @(posedge clk) disable iff (rst)
      (take && mem_req.addr > MAIN_LAST && mem_req.addr < EXP_BASE) |=> mem_rsp.err;
   endproperty
   a_outside: assert property (p_outside) else $error("gap address accepted");

   property p_main_off;
      @(posedge clk) disable iff (rst)
      (take && rg == RG_MAIN && !ctrl_ff[CTL_MAIN_EN]) |=> mem_rsp.err && !mem_rsp.merr;
   endproperty
   a_main_off: assert property (p_main_off) else $error("disabled main ram answered");

   property p_exp_wait;
      @(posedge clk) disable iff (rst)
      (take && !fault && rg == RG_EXP && ctrl_ff[CTL_WAIT]) |=> !mem_rsp.done ##1 mem_rsp.done;
   endproperty
   a_exp_wait: assert property (p_exp_wait) else $error("expansion wait not two cycles");

   property p_ecc_w0;
      @(posedge clk) disable iff (rst)
      (take && !fault && rg == RG_ECC && !ctrl_ff[CTL_WAIT] && !ecc_err)
         |=> !mem_rsp.done ##1 mem_rsp.done;
   endproperty
   a_ecc_w0: assert property (p_ecc_w0) else $error("ecc ram not two cycles");

   property p_ecc_w1_err;
      @(posedge clk) disable iff (rst)
      (take && !fault && rg == RG_ECC && ctrl_ff[CTL_WAIT] && ecc_err)
         |=> (!mem_rsp.done && !mem_rsp.ready) [*4] ##1 mem_rsp.done;
   endproperty
   a_ecc_w1_err: assert property (p_ecc_w1_err) else $error("ecc error access not five");

   property p_ecc_fix;
      @(posedge clk) disable iff (rst)
      (take && !fault && rg == RG_ECC && ecc_on && !mem_req.write && ecc_rd.single)
         |=> ##[0:4] (mem_rsp.done && mem_rsp.fixed && !mem_rsp.merr);
   endproperty
   a_ecc_fix: assert property (p_ecc_fix) else $error("single error not corrected");

   property p_stop;
      @(posedge clk) disable iff (rst)
      (take && rg == RG_ECC && ctrl_ff[CTL_STOP_EC]) |=> mem_rsp.err && mem_rsp.done;
   endproperty
   a_stop: assert property (p_stop) else $error("stopped ecc ram answered");

   property p_parity_flag;
      @(posedge clk) disable iff (rst)
      (take && !fault && !mem_req.write && rg == RG_MAIN && par_bad)
         |=> status_ff[EV_MAIN_PAR] && mem_rsp.merr;
   endproperty
   a_parity_flag: assert property (p_parity_flag) else $error("parity error missed");

   property p_irq_route;
      @(posedge clk) disable iff (rst)
      (|(status_ff & mask_ff))
         |-> (ctrl_ff[CTL_NMI] ? (nmi && !irq) : (irq && !nmi));
   endproperty
   a_irq_route: assert property (p_irq_route) else $error("error not routed to line");

   property p_exp_one;
      @(posedge clk) disable iff (rst)
      (take && !fault && rg == RG_EXP && !ctrl_ff[CTL_WAIT])
         |=> mem_rsp.done && mem_rsp.ready;
   endproperty
   a_exp_one: assert property (p_exp_one) else $error("expansion ram not one cycle");

   property p_ecc_w1_wr;
      @(posedge clk) disable iff (rst)
      (take && !fault && rg == RG_ECC && ctrl_ff[CTL_WAIT] && ecc_on && mem_req.write)
         |=> (!mem_rsp.done && !mem_rsp.ready) [*3] ##1 mem_rsp.done;
   endproperty
   a_ecc_w1_wr: assert property (p_ecc_w1_wr) else $error("ecc write not four cycles");

   property p_ecc_dbl;
      @(posedge clk) disable iff (rst)
      (take && !fault && rg == RG_ECC && ecc_on && !mem_req.write && ecc_rd.dbl)
         |=> ##[0:4] (mem_rsp.done && mem_rsp.merr && !mem_rsp.fixed);
   endproperty
   a_ecc_dbl: assert property (p_ecc_dbl) else $error("double error not flagged");

   property p_standby;
      @(posedge clk) disable iff (rst)
      (take && deep_standby) |=> mem_rsp.done && mem_rsp.err && !mem_rsp.merr;
   endproperty
   a_standby: assert property (p_standby) else $error("access taken in deep standby");

endmodule // onchip_ram_parity_ecc_ctrl

// *** mem_agent.sv ***
// memory bus master model driving the controller's memory port
`timescale 1ns/1ps
module mem_agent
   import ocram_pkg::*;
(
   input  wire logic     clk,
   input  wire mem_rsp_t mem_rsp,
   output mem_req_t      mem_req
);
   initial mem_req = '0;

   // -------------------------------------------------------------
   // one access: request held until taken, then wait for done
   // -------------------------------------------------------------
   // released fields are inverted so stale values never look valid
   task automatic xfer(input logic w, input logic [31:0] a, d, input int gap,
                       output mem_rsp_t r, output int n);
      repeat (gap) @(posedge clk);
      mem_req <= '{1'b1, w, a, d};
      do @(posedge clk); while (mem_rsp.ready !== 1'b1);
      mem_req <= '{1'b0, ~w, ~a, ~d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (mem_rsp.done !== 1'b1 && n < 20);
      r = mem_rsp;
   endtask
endmodule // mem_agent

// *** onchip_ram_parity_ecc_ctrl_bench.sv ***
// self-checking bench of the on-chip ram controller
`timescale 1ns/1ps
module onchip_ram_parity_ecc_ctrl_bench
   import ocram_pkg::*;
;
   logic        clk = 0;
   logic        rst = 1;
   logic        hsel = 0;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = '0;
   logic        hwrite = 0;
   logic [31:0] hwdata = '0;
   logic        dstb = 0;
   logic        hreadyout, hresp, irq, nmi;
   logic [31:0] hrdata, ctrl, d, v, a, inj;
   mem_req_t    mem_req;
   mem_rsp_t    mem_rsp, r;
   int          failures = 0;
   int          checks = 0;
   int          seed = 32'hcb52;
   int          n, g;
   logic [31:0] base[4] = '{32'h0, MAIN_BASE, EXP_BASE, ECC_BASE};
   logic [31:0] kv[4];
   logic [31:0] at[10] = '{MAIN_BASE, MAIN_LAST - 3, EXP_BASE, EXP_LAST - 3, ECC_BASE,
                           ECC_LAST - 3, MAIN_LAST + 1, EXP_BASE - 4, EXP_LAST + 1,
                           ECC_BASE - 4};
   logic [1:0]  eft[7] = '{2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h0};
   int          evt[7] = '{EV_MAIN_PAR, EV_EXP_PAR, EV_ECC_FIX, EV_ECC_DBL, EV_ECC_FIX,
                           EV_ECC_DBL, 0};

   onchip_ram_parity_ecc_ctrl onchip_ram_parity_ecc_ctrl_i (.clk(clk), .rst(rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .mem_req(mem_req), .mem_rsp(mem_rsp), .deep_standby(dstb),
      .irq(irq), .nmi(nmi));
   mem_agent mem_agent_i (.clk(clk), .mem_rsp(mem_rsp), .mem_req(mem_req));

   initial forever #5 clk = ~clk;

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, ad};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic setc(input logic [31:0] c);
      logic [31:0] t;
      ctrl = c;
      ahb(1'b1, REG_CTRL, c, t);
   endtask

   function automatic logic [1:0] rg(input logic [31:0] x);
      if (x <= MAIN_LAST) return 2'h1;
      if (x >= EXP_BASE && x <= EXP_LAST) return 2'h2;
      if (x >= ECC_BASE && x <= ECC_LAST) return 2'h3;
      return 2'h0;
   endfunction

   function automatic logic off(input logic [1:0] q);
      return q == 2'h0 || !ctrl[q - 1] || ctrl[q + 7] || dstb;
   endfunction

   // ef: expected {merr, fixed}; ecc ram, expansion ram with wait select and ecc errors stretch an access
   task automatic acc(input logic w, input logic [31:0] x, wd, input logic [1:0] ef,
                      input logic [31:0] xd);
      logic [1:0] q;
      logic       e;
      int         nx;
      q = rg(x);
      e = off(q);
      nx = e ? 1 : q != 2'h3 ? (q == 2'h2 && ctrl[CTL_WAIT] ? 2 : 1) :
           !ctrl[CTL_WAIT] ? (ef != 2'h0 ? 3 : 2) :
           ef != 2'h0 ? 5 : (!ctrl[CTL_ECC_FN] || !w ? 3 : 4);
      mem_agent_i.xfer(w, x, wd, $unsigned($random(seed)) % 2, r, n);
      chk(32'(n), 32'(nx));
      chk({29'h0, r.err, r.merr, r.fixed}, {29'h0, e, e ? 2'h0 : ef});
      if (!e && !w && ef != 2'h2)
         chk(r.rdata, xd);
   endtask

   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      ctrl = CTRL_RST;
      ahb(1'b0, REG_CTRL, '0, v);
      chk(v, 32'h0000_000f);
      chk({29'h0, hresp, irq, nmi}, 32'h0);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         setc({27'h0, c[0], c[1], 3'h7});
         foreach (at[i]) begin
            d = $random(seed);
            acc(1'b1, at[i], d, 2'h0, d);
            acc(1'b0, at[i], '0, 2'h0, d);
         end
      end
      $display("test decode done");
      for (int i = 6; i >= 0; i--) begin
         setc(i < 3 ? 32'hf & ~(32'h1 << i) : i < 6 ? 32'hf | 32'h100 << (i - 3) : 32'hf);
         for (int k = 1; k < 4; k++) begin
            d = $random(seed);
            acc(1'b1, base[k], d, 2'h0, d);
            if (!off(2'(k)))
               kv[k] = d;
         end
         setc(32'hf);
         for (int k = 1; k < 4; k++)
            acc(1'b0, base[k], '0, 2'h0, kv[k]);
      end
      $display("test enable done");
      for (int j = 0; j < 7; j++) begin
         g = j < 2 ? j + 1 : 3;
         setc({26'h0, j > 3, j > 3, j < 6, 3'h7});
         ahb(1'b1, REG_MASK, j == 1 ? 32'h0 : 32'h1f, v);
         n = $unsigned($random(seed)) % 32;
         inj = 32'h1 << n;
         if (j == 3 || j == 5)
            inj = inj | 32'h1 << ((n + 1 + $unsigned($random(seed)) % 31) % 32);
         ahb(1'b1, REG_INJECT, inj, v);
         d = $random(seed);
         a = base[g] + 32'h40;
         acc(1'b1, a, d, 2'h0, d);
         acc(1'b0, a, '0, eft[j], j == 6 ? d ^ inj : d);
         ahb(1'b0, REG_STATUS, '0, v);
         chk(v, j == 6 ? 32'h0 : 32'h1 << evt[j]);
         ahb(1'b0, REG_ERR_ADDR, '0, v);
         chk(v, a);
         ahb(1'b0, REG_MASK, '0, v);
         chk(v, j == 1 ? 32'h0 : 32'h1f);
         chk({30'h0, irq, nmi}, j == 1 || j == 6 ? 32'h0 : j > 3 ? 32'h1 : 32'h2);
         ahb(1'b1, REG_STATUS, 32'h1f, v);
         @(posedge clk);
         chk({30'h0, irq, nmi}, 32'h0);
      end
      $display("test errors done");
      dstb <= 1'b1;
      @(posedge clk);
      acc(1'b0, base[1], '0, 2'h0, '0);
      ahb(1'b0, REG_STATUS, '0, v);
      chk(v & 32'h10, 32'h10);
      dstb <= 1'b0;
      @(posedge clk);
      $display("test standby done");
      test_done;
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      test_done;
   end
endmodule // onchip_ram_parity_ecc_ctrl_bench
